// ===== logic/adcc_pkg.sv
package adcc_pkg;
   // register offsets on the plain register port
   localparam logic [3:0] OFF_CHAN_CTRL = 4'h0;
   localparam logic [3:0] OFF_TRIG_CMP = 4'h1;
   localparam logic [3:0] OFF_RESULT_HIGH = 4'h2;
   localparam logic [3:0] OFF_RESULT_LOW = 4'h3;
   localparam logic [3:0] OFF_CMP_HIGH = 4'h4;
   localparam logic [3:0] OFF_CMP_LOW = 4'h5;
   localparam logic [3:0] OFF_CONFIG = 4'h6;
   localparam logic [3:0] OFF_PIN_CTRL = 4'h7;

   // converter_configuration fields
   localparam int CFG_LOW_POWER = 7;
   localparam int CFG_DIV_HI = 6;
   localparam int CFG_DIV_LO = 5;
   localparam int CFG_LONG_SAMPLE = 4;
   localparam int CFG_RES_HI = 3;
   localparam int CFG_RES_LO = 2;
   localparam int CFG_CLK_HI = 1;
   localparam int CFG_CLK_LO = 0;

   // trigger_compare_status fields
   localparam int TCS_ACTIVE = 7;
   localparam int TCS_TRIG_SEL = 6;
   localparam int TCS_CMP_EN = 5;
   localparam int TCS_CMP_GT = 4;

   // channel_control_status fields
   localparam int CCS_COMPLETE = 7;
   localparam int CCS_IRQ_EN = 6;
   localparam int CCS_CONT = 5;

   // field codes
   localparam logic [1:0] RES_10BIT = 2'h2;
   localparam logic [1:0] CLK_BUS = 2'h0;
   localparam logic [1:0] CLK_BUS_HALF = 2'h1;
   localparam logic [4:0] CH_DISABLED = 5'h1F;

   // values after reset
   localparam logic [7:0] RST_CONFIG = 8'h00;
   localparam logic [7:0] RST_TRIG_CMP = 8'h00;
   localparam logic [6:0] RST_CHAN_CTRL = 7'h1F;
   localparam logic [7:0] RST_CMP = 8'h00;
   localparam logic [7:0] RST_PIN_CTRL = 8'h00;
   localparam logic [2:0] RST_DIV_CNT = 3'h0;

   typedef enum logic [0:0] {
      ADCC_IDLE = 1'b0,
      ADCC_BUSY = 1'b1
   } adcc_state_e;
endpackage : adcc_pkg

// ===== logic/adcc_clk_if.sv
interface adcc_clk_if;
   logic [1:0] div_sel;
   logic src_tick;
   logic conv_tick;
   modport ctrl (output div_sel, output src_tick, input conv_tick);
   modport div (input div_sel, input src_tick, output conv_tick);
endinterface : adcc_clk_if

// ===== logic/adcc_clk_div.sv
module adcc_clk_div
   import adcc_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // divider control
   adcc_clk_if.div ck
);
   logic [2:0] cnt_r;
   logic [2:0] limit;

   // divide by 1, 2, 4 or 8; code 00 passes every source tick
   always_comb begin
      case (ck.div_sel)
         2'h0: limit = 3'h0;
         2'h1: limit = 3'h1;
         2'h2: limit = 3'h3;
         default: limit = 3'h7;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt_r <= RST_DIV_CNT;
      end else if (ck.src_tick) begin
         cnt_r <= (cnt_r >= limit) ? RST_DIV_CNT : cnt_r + 3'h1;
      end
   end

   assign ck.conv_tick = ck.src_tick && (cnt_r >= limit);
endmodule : adcc_clk_div

// ===== logic/adcc_ctrl.sv
// What this block does
// - with hardware trigger selected, each rising trigger edge while idle starts a conversion.
// - trigger edges arriving during a conversion are ignored.
// - continuous with hardware trigger launches on first edge; later edges ignored.
// - hardware triggering works with every mode and option.
// - results are 10-bit or 8-bit per the resolution field.
// - software mode starts on a control write whose channel is not all ones.
// - continuous mode restarts on every completion, whether or not the compare lets the result be stored.
// - continuous runs start on write or trigger and repeat until aborted.
// - configuration holds low power, divider, long sample, resolution, clock select.
// - divider code 00 passes the input clock undivided.
// - resolution code 10 selects 10-bit conversions.
// - clock select 00 uses the bus clock.
// - trigger/compare bit 7 reads 1 while converting.
// - bit 6 trigger source, bit 5 compare enable, bit 4 greater-than.
// - trigger/compare bits 3:2 always read zero.
// - channel control bit 7 is a read-only completion flag.
// - bit 6 enables completion interrupt; bit 5 selects continuous.
// - bits 4:0 select the input channel; 00001 is channel 1.
// - compare value pair holds the value results are checked against.
// - pin control 0x02 makes only channel 1 pin analog.
// - divider divides by 1, 2, 4 or 8.
// - analog pins get output off, pullup off, input off, reads zero.
// - channel all ones disables the converter; reserved codes are undefined.
module adcc_ctrl
   import adcc_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // trigger and alternate clock pins
   input wire logic hw_trigger_in,
   input wire logic alt_clk_in,
   // analog core
   output logic core_start,
   output logic [4:0] core_channel,
   output logic core_res10,
   output logic core_long_sample,
   output logic core_low_power,
   output logic core_tick,
   input wire logic core_done,
   input wire logic [9:0] core_data,
   // port pins
   input wire logic [7:0] port_pins_in,
   output logic [7:0] pin_analog,
   output logic [7:0] port_read,
   // completion request
   output logic irq
);
   function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
      hit = (a == off);
   endfunction : hit

   adcc_clk_if ck ();
   adcc_clk_div u_div (
      .sys_clk(sys_clk),
      .rst(rst),
      .ck(ck)
   );

   logic [7:0] config_r;
   logic [3:0] trig_cmp_r;
   logic [6:0] chan_ctrl_r;
   logic complete_r;
   logic [7:0] cmp_high_r;
   logic [7:0] cmp_low_r;
   logic [7:0] pin_ctrl_r;
   logic [7:0] res_high_r;
   logic [7:0] res_low_r;
   logic frozen_r;
   logic [7:0] reg_rdata_r;
   logic start_r;
   logic half_r;
   adcc_state_e state_r;
   adcc_state_e state_nxt;
   logic [2:0] trig_sync_r;
   logic [2:0] alt_sync_r;
   logic [7:0] pin_s1_r;
   logic [7:0] pin_s2_r;

   logic ccs_wr;
   logic tcs_wr;
   logic rd_high;
   logic rd_low;
   logic hw_rise;
   logic sw_start;
   logic hw_start;
   logic restart;
   logic busy;
   logic res10;
   logic [9:0] res_val;
   logic [9:0] cmp_val;
   logic cmp_ok;
   logic store;

   assign ccs_wr = reg_wr && hit(reg_addr, OFF_CHAN_CTRL);
   assign tcs_wr = reg_wr && hit(reg_addr, OFF_TRIG_CMP);
   assign rd_high = reg_rd && hit(reg_addr, OFF_RESULT_HIGH);
   assign rd_low = reg_rd && hit(reg_addr, OFF_RESULT_LOW);
   assign busy = (state_r == ADCC_BUSY);

   // pin inputs pass two flops; edge seen between second and third
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         trig_sync_r <= 3'h0;
         alt_sync_r <= 3'h0;
         pin_s1_r <= 8'h00;
         pin_s2_r <= 8'h00;
      end else begin
         trig_sync_r <= {trig_sync_r[1:0], hw_trigger_in};
         alt_sync_r <= {alt_sync_r[1:0], alt_clk_in};
         pin_s1_r <= port_pins_in;
         pin_s2_r <= pin_s1_r;
      end
   end
   assign hw_rise = trig_sync_r[1] && !trig_sync_r[2];

   // configuration, compare value and pin control
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         config_r <= RST_CONFIG;
         trig_cmp_r <= RST_TRIG_CMP[7:4];
         chan_ctrl_r <= RST_CHAN_CTRL;
         cmp_high_r <= RST_CMP;
         cmp_low_r <= RST_CMP;
         pin_ctrl_r <= RST_PIN_CTRL;
      end else if (reg_wr) begin
         if (hit(reg_addr, OFF_CONFIG)) config_r <= reg_wdata;
         if (tcs_wr) trig_cmp_r <= reg_wdata[7:4];
         if (ccs_wr) chan_ctrl_r <= reg_wdata[6:0];
         if (hit(reg_addr, OFF_CMP_HIGH)) cmp_high_r <= reg_wdata;
         if (hit(reg_addr, OFF_CMP_LOW)) cmp_low_r <= reg_wdata;
         if (hit(reg_addr, OFF_PIN_CTRL)) pin_ctrl_r <= reg_wdata;
      end
   end

   // conversion clock source: bus, bus/2 or alternate pin
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         half_r <= 1'b0;
      end else begin
         half_r <= !half_r;
      end
   end
   always_comb begin
      case (config_r[CFG_CLK_HI:CFG_CLK_LO])
         CLK_BUS: ck.src_tick = 1'b1;
         CLK_BUS_HALF: ck.src_tick = half_r;
         default: ck.src_tick = alt_sync_r[1] && !alt_sync_r[2];
      endcase
   end
   assign ck.div_sel = config_r[CFG_DIV_HI:CFG_DIV_LO];

   // start sources
   assign sw_start = ccs_wr && !trig_cmp_r[TCS_TRIG_SEL - 4]
      && (reg_wdata[4:0] != CH_DISABLED);
   assign hw_start = trig_cmp_r[TCS_TRIG_SEL - 4] && hw_rise && !busy
      && !ccs_wr && (chan_ctrl_r[4:0] != CH_DISABLED);
   assign restart = busy && core_done && chan_ctrl_r[CCS_CONT];

   always_comb begin
      state_nxt = state_r;
      if (ccs_wr) begin
         state_nxt = sw_start ? ADCC_BUSY : ADCC_IDLE;
      end else begin
         case (state_r)
            ADCC_IDLE: if (hw_start) state_nxt = ADCC_BUSY;
            ADCC_BUSY: if (core_done && !restart) state_nxt = ADCC_IDLE;
            default: state_nxt = ADCC_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_r <= ADCC_IDLE;
         start_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         start_r <= sw_start || hw_start || (restart && !ccs_wr);
      end
   end

   // result formatting and compare
   assign res10 = (config_r[CFG_RES_HI:CFG_RES_LO] == RES_10BIT);
   assign res_val = res10 ? core_data : {2'h0, core_data[7:0]};
   assign cmp_val = res10 ? {cmp_high_r[1:0], cmp_low_r} : {2'h0, cmp_low_r};
   assign cmp_ok = !trig_cmp_r[TCS_CMP_EN - 4]
      || (trig_cmp_r[TCS_CMP_GT - 4] ? (res_val >= cmp_val) : (res_val < cmp_val));
   assign store = busy && core_done && cmp_ok;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         res_high_r <= 8'h00;
         res_low_r <= 8'h00;
      end else if (store && !frozen_r) begin
         res_high_r <= {6'h00, res_val[9:8]};
         res_low_r <= res_val[7:0];
      end
   end

   // a read of the high byte holds both bytes until the low byte is read
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         frozen_r <= 1'b0;
      end else if (rd_low) begin
         frozen_r <= 1'b0;
      end else if (rd_high) begin
         frozen_r <= 1'b1;
      end
   end

   // completion flag: a new completion wins over a clear in the same cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         complete_r <= 1'b0;
      end else if (store) begin
         complete_r <= 1'b1;
      end else if (ccs_wr || rd_low) begin
         complete_r <= 1'b0;
      end
   end

   // read data, one cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata_r <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            OFF_CHAN_CTRL: reg_rdata_r <= {complete_r, chan_ctrl_r};
            OFF_TRIG_CMP: reg_rdata_r <= {busy, trig_cmp_r[2:0], 4'h0};
            OFF_RESULT_HIGH: reg_rdata_r <= res_high_r;
            OFF_RESULT_LOW: reg_rdata_r <= res_low_r;
            OFF_CMP_HIGH: reg_rdata_r <= cmp_high_r;
            OFF_CMP_LOW: reg_rdata_r <= cmp_low_r;
            OFF_CONFIG: reg_rdata_r <= config_r;
            OFF_PIN_CTRL: reg_rdata_r <= pin_ctrl_r;
            default: reg_rdata_r <= 8'h00;
         endcase
      end
   end
   assign reg_rdata = reg_rdata_r;

   // outputs
   assign core_start = start_r;
   assign core_channel = chan_ctrl_r[4:0];
   assign core_res10 = res10;
   assign core_long_sample = config_r[CFG_LONG_SAMPLE];
   assign core_low_power = config_r[CFG_LOW_POWER];
   assign core_tick = ck.conv_tick;
   assign pin_analog = pin_ctrl_r;
   assign port_read = pin_s2_r & ~pin_ctrl_r;
   assign irq = complete_r && chan_ctrl_r[CCS_IRQ_EN];

   // checks
   sequence s_sw_cont_write;
      ccs_wr && reg_wdata[CCS_CONT] && !trig_cmp_r[TCS_TRIG_SEL - 4]
         && (reg_wdata[4:0] != CH_DISABLED);
   endsequence
   sequence s_launch;
      start_r && busy;
   endsequence
   sequence s_high_read;
      rd_high && !rd_low;
   endsequence
   sequence s_stay_busy;
      busy && !start_r;
   endsequence

   a_hw_edge_start: assert property (@(posedge sys_clk) disable iff (rst)
      trig_cmp_r[TCS_TRIG_SEL - 4] && hw_rise && !busy && !ccs_wr
      && chan_ctrl_r[4:0] != CH_DISABLED |=> s_launch)
      else $error("trigger edge did not start a conversion");
   a_busy_edge_ignored: assert property (@(posedge sys_clk) disable iff (rst)
      busy && hw_rise && !core_done && !ccs_wr |=> busy && !start_r)
      else $error("trigger edge acted on during a conversion");
   a_sw_cont_launch: assert property (@(posedge sys_clk) disable iff (rst)
      s_sw_cont_write |=> s_launch)
      else $error("software write did not launch continuous run");
   a_cont_restart: assert property (@(posedge sys_clk) disable iff (rst)
      busy && core_done && chan_ctrl_r[CCS_CONT] && !ccs_wr |=> s_launch)
      else $error("continuous conversion did not restart");
   a_disable_idle: assert property (@(posedge sys_clk) disable iff (rst)
      ccs_wr && reg_wdata[4:0] == CH_DISABLED |=> !busy && !start_r)
      else $error("disabled channel left converter running");
   a_done_flag: assert property (@(posedge sys_clk) disable iff (rst)
      store |=> complete_r)
      else $error("completion flag not set");
   a_flag_clear: assert property (@(posedge sys_clk) disable iff (rst)
      (ccs_wr || rd_low) && !store |=> !complete_r)
      else $error("completion flag not cleared");
   a_low_frozen: assert property (@(posedge sys_clk) disable iff (rst)
      s_high_read ##1 !rd_low |=> $stable(res_low_r))
      else $error("low byte changed while frozen");
   a_active_read: assert property (@(posedge sys_clk) disable iff (rst)
      reg_rd && reg_addr == OFF_TRIG_CMP |=> reg_rdata[7] == $past(busy)
      && reg_rdata[3:0] == 4'h0)
      else $error("active flag or reserved bits read wrong");
   a_irq_follows: assert property (@(posedge sys_clk) disable iff (rst)
      store && chan_ctrl_r[CCS_IRQ_EN] && !ccs_wr |=> irq)
      else $error("interrupt not raised on completion");
   a_sw_single_start: assert property (@(posedge sys_clk) disable iff (rst)
      ccs_wr && !trig_cmp_r[TCS_TRIG_SEL - 4] && reg_wdata[4:0] != CH_DISABLED |=> s_launch)
      else $error("software write did not start a conversion");
   a_sw_needs_write: assert property (@(posedge sys_clk) disable iff (rst)
      !trig_cmp_r[TCS_TRIG_SEL - 4] && !ccs_wr && !busy |=> !start_r)
      else $error("software mode started without a write");
   a_hw_write_idle: assert property (@(posedge sys_clk) disable iff (rst)
      ccs_wr && trig_cmp_r[TCS_TRIG_SEL - 4] |=> !busy && !start_r)
      else $error("control write started a conversion in trigger mode");
   a_cont_no_edge: assert property (@(posedge sys_clk) disable iff (rst)
      busy && chan_ctrl_r[CCS_CONT] && hw_rise && !core_done && !ccs_wr |=> s_stay_busy)
      else $error("trigger edge acted on during continuous run");
   a_single_stop: assert property (@(posedge sys_clk) disable iff (rst)
      busy && core_done && !chan_ctrl_r[CCS_CONT] && !ccs_wr |=> !busy && !start_r)
      else $error("single conversion did not stop");
   a_low_res_high: assert property (@(posedge sys_clk) disable iff (rst)
      store && !frozen_r && !res10 |=> res_high_r == 8'h00)
      else $error("8-bit result left bits in the high byte");
   a_res10_high: assert property (@(posedge sys_clk) disable iff (rst)
      store && !frozen_r && res10 |=> res_high_r[1:0] == $past(core_data[9:8]))
      else $error("10-bit result high bits not stored");
   a_undivided_tick: assert property (@(posedge sys_clk) disable iff (rst)
      config_r[CFG_DIV_HI:CFG_DIV_LO] == 2'h0
      && config_r[CFG_CLK_HI:CFG_CLK_LO] == CLK_BUS |-> core_tick)
      else $error("undivided bus clock missed a tick");
   a_cmp_miss: assert property (@(posedge sys_clk) disable iff (rst)
      busy && core_done && trig_cmp_r[TCS_CMP_EN - 4] && !cmp_ok |=> $stable(res_low_r))
      else $error("result stored although compare failed");
   a_disabled_no_start: assert property (@(posedge sys_clk) disable iff (rst)
      chan_ctrl_r[4:0] == CH_DISABLED && !ccs_wr |=> !start_r)
      else $error("disabled converter started a conversion");
endmodule : adcc_ctrl

// ===== bench/adcc_core_model.sv
module adcc_core_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // converter side
   input wire logic core_start,
   output logic core_done,
   output logic [9:0] core_data,
   // bench control
   input wire logic [7:0] lat,
   input wire logic [9:0] val
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt_r;
   logic busy_r;
   always_ff @(posedge sys_clk) begin
      core_done <= 1'b0;
      // data is only valid with done, so keep it moving otherwise
      core_data <= ~core_data;
      if (rst) begin
         busy_r <= 1'b0;
         cnt_r <= 8'h00;
         core_data <= 10'h155;
      end else if (core_start) begin
         busy_r <= 1'b1;
         cnt_r <= lat;
      end else if (busy_r && cnt_r == 8'h00) begin
         busy_r <= 1'b0;
         core_done <= 1'b1;
         core_data <= val;
      end else if (busy_r) begin
         cnt_r <= cnt_r - 8'h01;
      end
   end
endmodule : adcc_core_model

// ===== bench/tb.sv
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin err_total++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb
   import adcc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic hw_trigger_in = 1'b0;
   logic [7:0] port_pins_in = 8'h00;
   logic [7:0] lat = 8'h03;
   logic [9:0] val = 10'h000;
   logic [9:0] old_v;
   logic [7:0] reg_rdata, pin_analog, port_read, rd_v, cfg_v;
   logic core_start, core_res10, core_long_sample, core_low_power, core_tick, core_done, irq;
   logic [4:0] core_channel;
   logic [9:0] core_data;
   logic [31:0] rng = 32'hae3e_390b;
   // alternate clock pin, rising every fourth cycle
   logic [1:0] alt_cnt = 2'h0;
   int err_total = 0;
   int check_count = 0;
   int starts = 0;
   int dones = 0;
   int s0, d0, n;

   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) alt_cnt <= alt_cnt + 2'h1;
   always @(posedge sys_clk) begin
      if (core_start === 1'b1) starts++;
      if (core_done === 1'b1) dones++;
   end

   adcc_ctrl u_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_trigger_in(hw_trigger_in),
      .alt_clk_in(alt_cnt[1]), .core_start(core_start), .core_channel(core_channel),
      .core_res10(core_res10), .core_long_sample(core_long_sample),
      .core_low_power(core_low_power), .core_tick(core_tick), .core_done(core_done),
      .core_data(core_data), .port_pins_in(port_pins_in), .pin_analog(pin_analog),
      .port_read(port_read), .irq(irq));
   adcc_core_model u_core (.sys_clk(sys_clk), .rst(rst), .core_start(core_start),
      .core_done(core_done), .core_data(core_data), .lat(lat), .val(val));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic cmp_hit(input logic gt, input logic [9:0] r, input logic [9:0] c);
      return gt ? (r >= c) : (r < c);
   endfunction : cmp_hit

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      rd_v = reg_rdata;
   endtask : rd
   task automatic conv();
      int c;
      c = dones;
      for (int i = 0; i < 300 && dones == c; i++) @(posedge sys_clk);
      @(posedge sys_clk);
      `CHK("conv_done", 1'b1, dones != c)
   endtask : conv
   task automatic trig();
      @(posedge sys_clk);
      hw_trigger_in <= 1'b1;
      repeat (3) @(posedge sys_clk);
      hw_trigger_in <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask : trig
   task automatic close_out();
      if (err_total == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out

   initial begin
      #100000;
      err_total++;
      close_out();
   end

   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      rd(OFF_CHAN_CTRL);
      `CHK("ccs_rst", {1'b0, RST_CHAN_CTRL}, rd_v)
      // index 8 is unmapped
      for (int a = 1; a < 9; a++) begin
         rd(a[3:0]);
         `CHK("rst_val", 8'h00, rd_v)
      end
      for (int i = 0; i < 4; i++) begin
         rng = lfsr(rng);
         cfg_v = rng[7:0] & 8'hFC;
         wr(OFF_CONFIG, cfg_v);
         rd(OFF_CONFIG);
         `CHK("cfg", cfg_v, rd_v)
         `CHK("res10", cfg_v[3:2] == RES_10BIT, core_res10)
         `CHK("long", cfg_v[4], core_long_sample)
         `CHK("lowpw", cfg_v[7], core_low_power)
      end
      // codes 4 and 5 try the bus/2 and the alternate pin sources, undivided
      for (int d = 0; d < 6; d++) begin
         wr(OFF_CONFIG, (d < 4) ? 8'(d << 5) : 8'(d - 3));
         n = 0;
         repeat (64) begin
            @(negedge sys_clk);
            if (core_tick === 1'b1) n++;
         end
         `CHK("ticks", 64 >> ((d < 4) ? d : d - 3), n)
      end
      wr(OFF_TRIG_CMP, 8'h3C);
      rd(OFF_TRIG_CMP);
      `CHK("tcs", 8'h30, rd_v)
      wr(OFF_CONFIG, 8'h98);
      wr(OFF_TRIG_CMP, 8'h00);
      val <= 10'(rng);
      wr(OFF_CHAN_CTRL, 8'h41);
      #1;
      `CHK("start", 1'b1, core_start)
      rd(OFF_TRIG_CMP);
      `CHK("active", 8'h80, rd_v)
      conv();
      rd(OFF_CHAN_CTRL);
      `CHK("done", 8'hC1, rd_v)
      `CHK("irq", 1'b1, irq)
      `CHK("chan", 5'h01, core_channel)
      rd(OFF_RESULT_HIGH);
      `CHK("res_hi", {6'h00, val[9:8]}, rd_v)
      old_v = val;
      val <= ~val;
      wr(OFF_CHAN_CTRL, 8'h41);
      conv();
      rd(OFF_RESULT_LOW);
      `CHK("frozen", old_v[7:0], rd_v)
      rd(OFF_CHAN_CTRL);
      `CHK("clr", 8'h41, rd_v)
      `CHK("irq_off", 1'b0, irq)
      wr(OFF_CONFIG, 8'h00);
      wr(OFF_CHAN_CTRL, 8'h41);
      conv();
      rd(OFF_RESULT_LOW);
      `CHK("res8", val[7:0], rd_v)
      s0 = starts;
      wr(OFF_CHAN_CTRL, 8'h1F);
      repeat (5) @(posedge sys_clk);
      `CHK("off", s0, starts)
      // compare runs on 10-bit results
      wr(OFF_CONFIG, 8'h08);
      wr(OFF_CMP_HIGH, 8'h02);
      wr(OFF_CMP_LOW, 8'h00);
      for (int k = 0; k < 3; k++) begin
         val <= (k == 1) ? 10'h300 : 10'h100;
         wr(OFF_TRIG_CMP, {3'b001, k < 2, 4'h0});
         wr(OFF_CHAN_CTRL, 8'h01);
         conv();
         rd(OFF_CHAN_CTRL);
         `CHK("cmp", cmp_hit(k < 2, val, 10'h200), rd_v[7])
         rd(OFF_RESULT_LOW);
      end
      wr(OFF_CONFIG, 8'h90);
      wr(OFF_TRIG_CMP, 8'h40);
      lat <= 8'd20;
      s0 = starts;
      wr(OFF_CHAN_CTRL, 8'h01);
      repeat (3) @(posedge sys_clk);
      `CHK("hw_nosw", s0, starts)
      trig();
      `CHK("hw_start", s0 + 1, starts)
      trig();
      conv();
      `CHK("hw_busy", s0 + 1, starts)
      lat <= 8'd4;
      wr(OFF_CHAN_CTRL, 8'h21);
      s0 = starts;
      d0 = dones;
      trig();
      repeat (30) @(posedge sys_clk);
      trig();
      repeat (20) @(posedge sys_clk);
      n = starts - s0;
      `CHK("cont", 1'b1, n > 5 && n - (dones - d0) <= 1)
      wr(OFF_CHAN_CTRL, 8'h1F);
      repeat (10) @(posedge sys_clk);
      s0 = starts;
      repeat (20) @(posedge sys_clk);
      `CHK("abort", s0, starts)
      rd(OFF_TRIG_CMP);
      `CHK("idle", 8'h40, rd_v)
      port_pins_in <= 8'hFF;
      wr(OFF_PIN_CTRL, 8'h02);
      repeat (5) @(posedge sys_clk);
      `CHK("analog", 8'h02, pin_analog)
      `CHK("port", 8'hFD, port_read)
      close_out();
   end
endmodule : tb
